// File: hw/canip_map.svh
// register offsets, bit positions and reset values of the can irq block
// assumes byte addressing over a 32-bit axi4-lite bus
`ifndef CANIP_MAP_SVH
`define CANIP_MAP_SVH

`define CANIP_OFF_ENABLE 8'h00
`define CANIP_OFF_PRIO 8'h04
`define CANIP_OFF_TX_BUFFER_IRQ_ENABLE 8'h08
`define CANIP_OFF_BIE 8'h0C
`define CANIP_OFF_FLAG 8'h10
`define CANIP_OFF_MODE 8'h14
`define CANIP_OFF_PEND 8'h18

`define CANIP_ENABLE_RST 8'h00
`define CANIP_PRIO_RST 8'hFF
`define CANIP_ZERO8 8'h00
`define CANIP_ALL8 8'hFF

`define CANIP_B_IRX 7
`define CANIP_B_WAK 6
`define CANIP_B_ERR 5
`define CANIP_B_TX2 4
`define CANIP_B_TX1 3
`define CANIP_B_TX0 2
`define CANIP_B_RX1 1
`define CANIP_B_RX0 0

`define CANIP_LEGACY_ONLY 8'h0C
`define CANIP_BIT0_MASK 8'h01
`define CANIP_TX_BUFFER_IRQ_ENABLE_MASK 8'h1C
`define CANIP_MODE_BAD 2'h3

`define CANIP_RESP_OK 2'h0
`define CANIP_RESP_ERR 2'h2

`endif

// File: hw/canip_pkg.sv
// types shared by the can irq block
// assumes the map header carries all numbers
package canip_pkg;

  typedef enum logic [1:0] {
    canip_legacy = 2'b00,
    canip_enhanced = 2'b01,
    canip_fifo = 2'b10
  } canip_mode_t;

  // one-cycle event pulses from the can engine
  typedef struct packed {
    logic invalid_msg;
    logic bus_wake;
    logic module_error;
    logic [2:0] tx_done;
    logic [1:0] rx_done;
    logic [5:0] prog_done;
    logic fifo_wm;
  } canip_evt_t;

endpackage

// File: hw/canip_top.sv
// can interrupt enable, priority and buffer gating with axi4-lite registers
// assumes event pulses come from logic on aclk
//
// Functional notes
// - enable bit 7 gates invalid-message interrupt
// - enable bit 6 gates bus wake-up interrupt
// - enable bit 5 gates module error interrupt
// - legacy: enable bit 4 is tx buffer 2
// - other modes: bit 4 global tx enable
// - other modes: bit 1 global rx enable
// - legacy: bits 1,0 are rx buffers 1,0
// - bit 0 zero enhanced, fifo watermark in fifo
// - other modes hold bits 3,2 at zero
// - priority bit per source, resets to one
// - priority bits 4,1 for combined tx/rx
// - priority bit 0 rx0/watermark, zero enhanced
// - tx enable register bits 4-2 per buffer
// - other tx enable register bits read zero
// - buffer enable registers only in modes 1,2
// - tx irq needs own and global enable
// - buffer enable bits 7-2 programmable buffers
// - buffer enable bits 1-0 dedicated rx buffers
// - buffer enable needs global tx/rx enable
// - other modes: flag bit 4 on any tx done
// - fifo mode flag bit 0 at watermark
`timescale 1ns/1ps
`include "canip_map.svh"

module canip_top #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // can engine events
  input wire canip_pkg::canip_evt_t can_evt,
  input wire logic [5:0] prog_is_tx,
  // interrupt requests to the core
  output logic irq_high,
  output logic irq_low
);

  // register state
  logic [7:0] enable_reg, prio_reg, tx_buffer_irq_enable_reg, bie_reg;
  canip_pkg::canip_mode_t mode_reg;
  logic irx_flag_reg, wak_flag_reg, err_flag_reg;
  logic [2:0] tx_pend_reg;
  logic [1:0] rx_pend_reg;
  logic [5:0] prog_pend_reg;
  logic fifo_pend_reg;

  // bus holding state
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [7:0] w_data_reg;
  logic w_strb_reg;
  logic [31:0] w_full_data_reg;

  // mode views
  logic legacy, enhanced, fifo_mode;
  logic [7:0] view_mask, enable_eff, prio_eff, tx_buffer_irq_enable_eff, bie_eff;
  logic [7:0] flag_view, src_req;
  logic [11:0] pend_view;
  logic tx_any, rx_any, tx_gate, rx_gate;

  // write decode
  logic wr_go, wr_hit;
  logic [7:0] wr_off, rd_off, flag_clr;
  logic wr_en_sel, wr_prio_sel, wr_tx_buffer_irq_enable_sel, wr_bie_sel;
  logic wr_flag_sel, wr_mode_sel, wr_pend_sel;
  logic [11:0] pend_clr;
  logic [31:0] rd_data;
  logic rd_hit;

  assign legacy = (mode_reg == canip_pkg::canip_legacy);
  assign enhanced = (mode_reg == canip_pkg::canip_enhanced);
  assign fifo_mode = (mode_reg == canip_pkg::canip_fifo);

  // bits forced to zero outside legacy, bit 0 forced in enhanced
  always_comb begin
    view_mask = `CANIP_ALL8;
    if (!legacy) begin
      view_mask = view_mask & ~`CANIP_LEGACY_ONLY;
    end
    if (enhanced) begin
      view_mask = view_mask & ~`CANIP_BIT0_MASK;
    end
  end

  assign enable_eff = enable_reg & view_mask;
  assign prio_eff = prio_reg & view_mask;
  assign tx_buffer_irq_enable_eff = legacy ? `CANIP_ZERO8 : tx_buffer_irq_enable_reg;
  assign bie_eff = legacy ? `CANIP_ZERO8 : bie_reg;

  // combined buffer flags
  assign tx_any = (|tx_pend_reg) | (|(prog_pend_reg & prog_is_tx));
  assign rx_any = (|rx_pend_reg) | (|(prog_pend_reg & ~prog_is_tx));

  // per-buffer gating under the global enables
  always_comb begin
    tx_gate = enable_eff[`CANIP_B_TX2] & (
      (|(tx_pend_reg & tx_buffer_irq_enable_eff[4:2])) |
      (|(prog_pend_reg & prog_is_tx & bie_eff[7:2])));
    rx_gate = enable_eff[`CANIP_B_RX1] & (
      (|(rx_pend_reg & bie_eff[1:0])) |
      (|(prog_pend_reg & ~prog_is_tx & bie_eff[7:2])));
  end

  // flag view by functional mode
  always_comb begin
    flag_view = `CANIP_ZERO8;
    flag_view[`CANIP_B_IRX] = irx_flag_reg;
    flag_view[`CANIP_B_WAK] = wak_flag_reg;
    flag_view[`CANIP_B_ERR] = err_flag_reg;
    if (legacy) begin
      flag_view[`CANIP_B_TX2] = tx_pend_reg[2];
      flag_view[`CANIP_B_TX1] = tx_pend_reg[1];
      flag_view[`CANIP_B_TX0] = tx_pend_reg[0];
      flag_view[`CANIP_B_RX1] = rx_pend_reg[1];
      flag_view[`CANIP_B_RX0] = rx_pend_reg[0];
    end else begin
      flag_view[`CANIP_B_TX2] = tx_any;
      flag_view[`CANIP_B_RX1] = rx_any;
      flag_view[`CANIP_B_RX0] = fifo_mode & fifo_pend_reg;
    end
  end

  assign pend_view = {fifo_pend_reg, prog_pend_reg, rx_pend_reg, tx_pend_reg};

  // source requests
  always_comb begin
    src_req = flag_view & enable_eff;
    if (!legacy) begin
      src_req[`CANIP_B_TX2] = tx_gate;
      src_req[`CANIP_B_RX1] = rx_gate;
      src_req[`CANIP_B_RX0] = fifo_mode & fifo_pend_reg &
        enable_eff[`CANIP_B_RX0];
    end
  end

  // interrupt outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_high <= 1'b0;
      irq_low <= 1'b0;
    end else begin
      irq_high <= |(src_req & prio_eff);
      irq_low <= |(src_req & ~prio_eff);
    end
  end

  // write address channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      aw_addr_reg <= '0;
    end else if (s_axi_awready && s_axi_awvalid) begin
      s_axi_awready <= 1'b0;
      aw_addr_reg <= s_axi_awaddr;
    end else if (wr_go) begin
      s_axi_awready <= 1'b1;
    end
  end

  // write data channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b1;
      w_full_data_reg <= '0;
      w_strb_reg <= 1'b0;
    end else if (s_axi_wready && s_axi_wvalid) begin
      s_axi_wready <= 1'b0;
      w_full_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb[0];
    end else if (wr_go) begin
      s_axi_wready <= 1'b1;
    end
  end

  assign w_data_reg = w_full_data_reg[7:0];
  assign wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wr_off = {aw_addr_reg[7:2], 2'b00};

  always_comb begin
    wr_hit = 1'b1;
    case (wr_off)
      `CANIP_OFF_ENABLE, `CANIP_OFF_PRIO, `CANIP_OFF_TX_BUFFER_IRQ_ENABLE,
      `CANIP_OFF_BIE, `CANIP_OFF_FLAG, `CANIP_OFF_MODE,
      `CANIP_OFF_PEND: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
    if (ADDR_W > 8 && |(aw_addr_reg >> 8)) begin
      wr_hit = 1'b0;
    end
  end

  assign wr_en_sel = wr_go && w_strb_reg && wr_off == `CANIP_OFF_ENABLE;
  assign wr_prio_sel = wr_go && w_strb_reg && wr_off == `CANIP_OFF_PRIO;
  assign wr_tx_buffer_irq_enable_sel = wr_go && w_strb_reg && wr_off == `CANIP_OFF_TX_BUFFER_IRQ_ENABLE;
  assign wr_bie_sel = wr_go && w_strb_reg && wr_off == `CANIP_OFF_BIE;
  assign wr_flag_sel = wr_go && w_strb_reg && wr_off == `CANIP_OFF_FLAG;
  assign wr_mode_sel = wr_go && w_strb_reg && wr_off == `CANIP_OFF_MODE;
  assign wr_pend_sel = wr_go && wr_off == `CANIP_OFF_PEND;

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CANIP_RESP_OK;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? `CANIP_RESP_OK : `CANIP_RESP_ERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // enable and priority registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable_reg <= `CANIP_ENABLE_RST;
    end else if (wr_en_sel) begin
      enable_reg <= w_data_reg & view_mask;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prio_reg <= `CANIP_PRIO_RST;
    end else if (wr_prio_sel) begin
      prio_reg <= (w_data_reg & view_mask) | (prio_reg & ~view_mask);
    end
  end

  // buffer enable registers, writes ignored in legacy
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_buffer_irq_enable_reg <= `CANIP_ZERO8;
    end else if (wr_tx_buffer_irq_enable_sel && !legacy) begin
      tx_buffer_irq_enable_reg <= w_data_reg & `CANIP_TX_BUFFER_IRQ_ENABLE_MASK;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bie_reg <= `CANIP_ZERO8;
    end else if (wr_bie_sel && !legacy) begin
      bie_reg <= w_data_reg;
    end
  end

  // functional mode, reserved code ignored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_reg <= canip_pkg::canip_legacy;
    end else if (wr_mode_sel && w_data_reg[1:0] != `CANIP_MODE_BAD) begin
      mode_reg <= canip_pkg::canip_mode_t'(w_data_reg[1:0]);
    end
  end

  // write-one-to-clear decode of the flag view
  always_comb begin
    flag_clr = wr_flag_sel ? w_data_reg : `CANIP_ZERO8;
    pend_clr = wr_pend_sel ? w_full_data_reg[11:0] : 12'h000;
    if (legacy) begin
      pend_clr[2:0] = pend_clr[2:0] | flag_clr[4:2];
      pend_clr[4:3] = pend_clr[4:3] | flag_clr[1:0];
    end else begin
      if (flag_clr[`CANIP_B_TX2]) begin
        pend_clr[2:0] = 3'h7;
        pend_clr[10:5] = pend_clr[10:5] | prog_is_tx;
      end
      if (flag_clr[`CANIP_B_RX1]) begin
        pend_clr[4:3] = 2'h3;
        pend_clr[10:5] = pend_clr[10:5] | ~prog_is_tx;
      end
      pend_clr[11] = pend_clr[11] | (fifo_mode & flag_clr[`CANIP_B_RX0]);
    end
  end

  // sticky event flags, set wins over clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irx_flag_reg <= 1'b0;
      wak_flag_reg <= 1'b0;
      err_flag_reg <= 1'b0;
    end else begin
      irx_flag_reg <= (irx_flag_reg & ~flag_clr[`CANIP_B_IRX]) |
        can_evt.invalid_msg;
      wak_flag_reg <= (wak_flag_reg & ~flag_clr[`CANIP_B_WAK]) |
        can_evt.bus_wake;
      err_flag_reg <= (err_flag_reg & ~flag_clr[`CANIP_B_ERR]) |
        can_evt.module_error;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_pend_reg <= 3'h0;
      rx_pend_reg <= 2'h0;
      prog_pend_reg <= 6'h00;
      fifo_pend_reg <= 1'b0;
    end else begin
      tx_pend_reg <= (tx_pend_reg & ~pend_clr[2:0]) | can_evt.tx_done;
      rx_pend_reg <= (rx_pend_reg & ~pend_clr[4:3]) | can_evt.rx_done;
      prog_pend_reg <= (prog_pend_reg & ~pend_clr[10:5]) |
        can_evt.prog_done;
      fifo_pend_reg <= (fifo_pend_reg & ~pend_clr[11]) |
        (fifo_mode & can_evt.fifo_wm);
    end
  end

  // read mux
  assign rd_off = {s_axi_araddr[7:2], 2'b00};

  always_comb begin
    rd_data = 32'h0000_0000;
    rd_hit = 1'b1;
    case (rd_off)
      `CANIP_OFF_ENABLE: rd_data[7:0] = enable_eff;
      `CANIP_OFF_PRIO: rd_data[7:0] = prio_eff;
      `CANIP_OFF_TX_BUFFER_IRQ_ENABLE: rd_data[7:0] = tx_buffer_irq_enable_eff;
      `CANIP_OFF_BIE: rd_data[7:0] = bie_eff;
      `CANIP_OFF_FLAG: rd_data[7:0] = flag_view;
      `CANIP_OFF_MODE: rd_data[1:0] = mode_reg;
      `CANIP_OFF_PEND: rd_data[11:0] = pend_view;
      default: rd_hit = 1'b0;
    endcase
    if (ADDR_W > 8 && |(s_axi_araddr >> 8)) begin
      rd_hit = 1'b0;
      rd_data = 32'h0000_0000;
    end
  end

  // read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `CANIP_RESP_OK;
    end else if (s_axi_arready && s_axi_arvalid) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_data;
      s_axi_rresp <= rd_hit ? `CANIP_RESP_OK : `CANIP_RESP_ERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule

// File: verif/canip_checker.sv
// checker for the can irq block bus and request timing
// assumes a bind onto canip_top
`timescale 1ns/1ps
module canip_checker (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // requests
  input wire canip_pkg::canip_evt_t can_evt,
  input wire logic irq_high,
  input wire logic irq_low
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  property p_wr_lat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      && !s_axi_bvalid |-> ##2 s_axi_bvalid;
  endproperty
  a_wr_lat: assert property (p_wr_lat)
    else $error("write answer late");
  property p_aw_low;
    s_axi_awvalid && s_axi_awready && !s_axi_bvalid |=> !s_axi_awready;
  endproperty
  a_aw_low: assert property (p_aw_low)
    else $error("address ready not dropped");
  property p_b_drop;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready;
  endproperty
  a_b_drop: assert property (p_b_drop)
    else $error("write answer stuck");
  property p_rd_lat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_rd_lat: assert property (p_rd_lat)
    else $error("read answer late");
  property p_r_drop;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready;
  endproperty
  a_r_drop: assert property (p_r_drop)
    else $error("read answer stuck");
  property p_bresp;
    s_axi_bvalid |-> s_axi_bresp == 2'h0 || s_axi_bresp == 2'h2;
  endproperty
  a_bresp: assert property (p_bresp)
    else $error("bad write response");
  property p_irq_rise;
    $rose(irq_high || irq_low) |-> $past(can_evt, 2) != '0
      || $past(s_axi_bvalid);
  endproperty
  a_irq_rise: assert property (p_irq_rise)
    else $error("request without cause");
  property p_irq_fall;
    $fell(irq_high || irq_low) |-> $past(s_axi_bvalid);
  endproperty
  a_irq_fall: assert property (p_irq_fall)
    else $error("request dropped without write");
  c_high: cover property (irq_high);
  c_low: cover property (irq_low);
  c_err: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule

bind canip_top canip_checker u_chk (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
  .can_evt, .irq_high, .irq_low
);

// File: verif/canip_core_model.sv
// core-side model counting taken interrupt requests
// assumes level requests on aclk
`timescale 1ns/1ps
module canip_core_model (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // requests
  input wire logic irq_high,
  input wire logic irq_low,
  // counts of taken requests
  output logic [7:0] high_taken,
  output logic [7:0] low_taken
);
  logic high_q;
  logic low_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      high_q <= 1'h0;
      low_q <= 1'h0;
      high_taken <= 8'h00;
      low_taken <= 8'h00;
    end else begin
      high_q <= irq_high;
      low_q <= irq_low;
      if (irq_high && !high_q) high_taken <= high_taken + 8'h01;
      if (irq_low && !low_q) low_taken <= low_taken + 8'h01;
    end
  end
endmodule

// File: verif/canip_tb_top.sv
// testbench for the can irq block
// assumes the checker is bound and the core model counts requests
`timescale 1ns/1ps
module can_interrupt_enable_priority_tb_top;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, irq_high, irq_low;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata, rd_data;
  canip_pkg::canip_evt_t can_evt = '0;
  logic [5:0] prog_is_tx = 6'h00;
  logic [7:0] high_taken, low_taken;
  int err_count = 0;
  int n_compared = 0;

  always #50 aclk = ~aclk;

  canip_top DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .can_evt, .prog_is_tx,
    .irq_high, .irq_low);
  canip_core_model core (.aclk, .aresetn, .irq_high, .irq_low,
    .high_taken, .low_taken);

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw;
    logic w;
    aw = 1'h1;
    w = 1'h1;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (aw || w) begin
      @(posedge aclk);
      if (aw && s_axi_awready) begin
        aw = 1'h0;
        s_axi_awvalid <= 1'h0;
      end
      if (w && s_axi_wready) begin
        w = 1'h0;
        s_axi_wvalid <= 1'h0;
      end
    end
    while (!s_axi_bvalid) @(posedge aclk);
    resp = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    do @(posedge aclk); while (!s_axi_rvalid);
    rd_data = s_axi_rdata;
    s_axi_rready <= 1'h0;
    chk(rd_data, exp);
  endtask

  task automatic pulse(input int b);
    @(posedge aclk);
    can_evt <= canip_pkg::canip_evt_t'(15'h1 << b);
    @(posedge aclk);
    can_evt <= '0;
  endtask

  task automatic irq(input logic h, input logic l);
    repeat (3) @(posedge aclk);
    chk(32'({irq_high, irq_low}), 32'({h, l}));
  endtask

  task automatic t_reset();
    rdc(8'h04, 32'hFF);
    irq(1'h0, 1'h0);
    s_axi_wstrb <= 4'hE;
    wr(8'h04, 32'h00);
    s_axi_wstrb <= 4'hF;
    rdc(8'h04, 32'hFF);
    wr(8'h40, 32'hFF);
    chk(32'(resp), 32'h2);
    wr(8'h08, 32'hFF);
    rdc(8'h08, 32'h0);
  endtask

  // each legacy source: gated when off, low level when its prio is 0
  task automatic t_legacy();
    for (int i = 0; i < 8; i++) begin
      wr(8'h00, 32'h0);
      wr(8'h04, 32'(8'hFF ^ (8'h01 << i)));
      pulse(i + 7);
      irq(1'h0, 1'h0);
      wr(8'h00, 32'(8'h01 << i));
      irq(1'h0, 1'h1);
      wr(8'h10, 32'(8'h01 << i));
      irq(1'h0, 1'h0);
    end
    chk(32'(low_taken), 32'h8);
  endtask

  task automatic t_enh();
    wr(8'h14, 32'h1);
    wr(8'h00, 32'hFF);
    rdc(8'h00, 32'hF2);
    wr(8'h04, 32'hFF);
    rdc(8'h04, 32'hF2);
    wr(8'h08, 32'hFF);
    rdc(8'h08, 32'h1C);
    wr(8'h00, 32'h10);
    pulse(9);
    irq(1'h1, 1'h0);
    rdc(8'h10, 32'h10);
    wr(8'h08, 32'h0);
    irq(1'h0, 1'h0);
    wr(8'h08, 32'h1C);
    irq(1'h1, 1'h0);
    wr(8'h00, 32'h0);
    irq(1'h0, 1'h0);
    wr(8'h10, 32'h10);
    wr(8'h00, 32'h02);
    wr(8'h0C, 32'h01);
    wr(8'h04, 32'hFD);
    pulse(7);
    irq(1'h0, 1'h1);
    wr(8'h00, 32'h0);
    irq(1'h0, 1'h0);
    wr(8'h00, 32'h02);
    irq(1'h0, 1'h1);
    wr(8'h0C, 32'h0);
    irq(1'h0, 1'h0);
    wr(8'h10, 32'h02);
    @(posedge aclk);
    prog_is_tx <= 6'h01;
    wr(8'h0C, 32'h04);
    wr(8'h00, 32'h10);
    pulse(1);
    irq(1'h1, 1'h0);
    wr(8'h10, 32'h10);
    chk(32'(high_taken), 32'h3);
  endtask

  task automatic t_fifo();
    wr(8'h14, 32'h2);
    wr(8'h00, 32'h01);
    wr(8'h04, 32'hFE);
    pulse(0);
    irq(1'h0, 1'h1);
    rdc(8'h10, 32'h01);
    wr(8'h14, 32'h3);
    rdc(8'h14, 32'h2);
    rdc(8'h18, 32'h800);
    wr(8'h18, 32'h800);
    irq(1'h0, 1'h0);
    chk(32'(low_taken), 32'hB);
  endtask

  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge aclk);
    err_count++;
    end_of_test();
  end

  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    t_reset();
    t_legacy();
    t_enh();
    t_fifo();
    end_of_test();
  end
endmodule
